// ==== logic/dpw_wiper_top.sv ====
// Top: command, restore and store logic of a two-wiper potentiometer
`timescale 1ns/1ps
module dpw_wiper_top
  import dpw_pkg::*;
#(
  parameter int WW         = WIPER_W,
  parameter int REST_CYC_P = REST_CYC,
  parameter int NVWR_CYC_P = NVWR_CYC
) (
  // Clock and reset
  input  logic          REF_CLK,
  input  logic          RESETN,
  // AHB-Lite slave
  input  logic          HSEL,
  input  logic [31:0]   HADDR,
  input  logic [1:0]    HTRANS,
  input  logic          HWRITE,
  input  logic [2:0]    HSIZE,
  input  logic [31:0]   HWDATA,
  input  logic          HREADY,
  output logic [31:0]   HRDATA,
  output logic          HREADYOUT,
  output logic          HRESP,
  // Serial bus and straps
  input  logic          SCL,
  input  logic          SDA_I,
  output logic          SDA_O,
  output logic          SDA_OE,
  input  logic          ADDR_SELECT_HI,
  input  logic          ADDR_SELECT_LO,
  input  logic          WP_N,
  // Wiper outputs
  output logic [WW-1:0] WIPER0,
  output logic [WW-1:0] WIPER1,
  output logic          NV_READ_ACTIVE
);
  // ****************************************
  // Elaboration checks and constants
  // ****************************************
  if (WW < 2 || WW > 8) begin : g_bad_w
    $error("dpw_wiper_top: WW must be 2 to 8");
  end
  if (REST_CYC_P < 1 || NVWR_CYC_P < 2) begin : g_bad_t
    $error("dpw_wiper_top: cycle counts too small");
  end

  localparam int            CW   = $clog2(REST_CYC_P + 1);
  localparam logic [WW-1:0] MID  = {1'b1, {(WW - 1){1'b0}}};
  localparam logic [WW-1:0] FULL = '1;
  localparam logic [WW-1:0] ONE  = WW'(1);

  // ****************************************
  // Declarations
  // ****************************************
  dpw_state_e           st_r;
  dpw_state_e           st_nxt;
  logic [CW-1:0]        cnt_r;
  logic [CW-1:0]        cnt_nxt;
  logic [1:0]           ldm_r;
  logic [1:0]           ldm_nxt;
  logic [1:0][WW-1:0]   w_r;
  logic [1:0][WW-1:0]   w_nxt;
  logic [1:0][WW-1:0]   nv_rd;
  logic                 nv_busy;
  logic                 nv_rd_r;
  logic                 wp_s1_r;
  logic                 wp_s2_r;
  logic [7:0]           ins_r;
  logic [16:0]          cmd_r;
  logic                 ap_wr_r;
  logic [7:0]           ap_a_r;
  logic [31:0]          rdata_r;
  logic                 rdy_r;
  logic                 resp_r;
  dpw_byte_s            rx;
  dpw_nvwr_s            nvwr;
  wire                  busy = st_r != ST_IDLE;

  // Channel select decode shared by both instruction forms
  function automatic logic [1:0] sel_mask(input logic [4:0] a);
    sel_mask = {a == SEL_CH1, a == SEL_CH0};
  endfunction

  // One shift or step on a wiper value
  function automatic logic [WW-1:0] op_val(input logic [3:0] c, input logic [WW-1:0] v);
    op_val = v;
    case (c)
      C_INC1, C_INCA: op_val = (v == FULL) ? v : v + ONE;
      C_DEC1, C_DECA: op_val = (v == '0) ? v : v - ONE;
      C_DBL1, C_DBLA: op_val = v[WW-1] ? FULL :
                               ((v == '0) ? ONE : (v << 1));
      C_HALF1, C_HALFA: op_val = v >> 1;
      default: op_val = v;
    endcase
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  // Serial front end is told busy so it refuses its address
  dpw_i2c_fe u_fe (
    .clk    (REF_CLK),
    .rst_n  (RESETN),
    .scl    (SCL),
    .sda_i  (SDA_I),
    .ad_hi  (ADDR_SELECT_HI),
    .ad_lo  (ADDR_SELECT_LO),
    .sda_o  (SDA_O),
    .sda_oe (SDA_OE),
    .busy   (busy),
    .rx     (rx)
  );

  dpw_nvstore #(
    .WW         (WW),
    .NVWR_CYC_P (NVWR_CYC_P),
    .NV_INIT    (MID)
  ) u_nv (
    .clk   (REF_CLK),
    .rst_n (RESETN),
    .wr    (nvwr),
    .busy  (nv_busy),
    .rd    (nv_rd)
  );

  // ****************************************
  // Write protect pin
  // ****************************************
  // Held protected until the pin is sampled, so a floating pin never opens
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      wp_s1_r <= 1'b0;
      wp_s2_r <= 1'b0;
    end else begin
      wp_s1_r <= WP_N;
      wp_s2_r <= wp_s1_r;
    end
  end
  wire wp_prot = ~wp_s2_r;

  // ****************************************
  // Command sources
  // ****************************************
  // Serial instruction in register form waits for its data byte
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      ins_r <= 8'h00;
    end else if (rx.valid && !rx.is_data) begin
      ins_r <= rx.dat;
    end
  end

  // Serial traffic wins a clash; software polls busy before writing
  wire       ap_take = HSEL & HREADY & HTRANS[1];
  wire       hit     = HADDR[31:8] == 24'h000000;
  wire       i2c_ex  = rx.valid & (rx.is_data | rx.dat[7]);
  wire       ahb_cw  = ap_wr_r & (ap_a_r == A_CMD);
  wire       ahb_ex  = ahb_cw & ~i2c_ex;
  wire       ex      = (i2c_ex | ahb_ex) & (st_r == ST_IDLE);
  wire [7:0] ins     = i2c_ex ? (rx.is_data ? ins_r : rx.dat) : HWDATA[7:0];
  wire       has_dat = i2c_ex ? rx.is_data : HWDATA[16];
  wire [7:0] dat     = i2c_ex ? rx.dat : HWDATA[15:8];

  // ****************************************
  // Instruction decode
  // ****************************************
  wire       is_cmd = ins[7];
  wire [3:0] code   = ins[6:3];
  wire [1:0] chm    = sel_mask({2'b00, ins[2:0]});
  wire       reg_nv = ins[5];
  wire [1:0] rm     = sel_mask(ins[4:0]);
  wire       all_c  = code inside {C_HALFA, C_DECA, C_DBLA, C_INCA};
  wire       is_op  = all_c | (code inside {C_HALF1, C_DEC1, C_DBL1, C_INC1});
  wire [1:0] tm     = all_c ? 2'b11 : chm;
  wire       c_ex   = ex & is_cmd;
  wire       r_ex   = ex & ~is_cmd & has_dat;

  // Restores are reads of the store and pass the protect gate
  wire       op_ok  = c_ex & is_op & ~wp_prot;
  wire       rw_ok  = r_ex & ~reg_nv & ~wp_prot;
  wire       st_ok  = c_ex & (code == C_STORE) & (|chm) & ~wp_prot;
  wire       rnv_ok = r_ex & reg_nv & (|rm) & ~wp_prot;
  wire       r1_go  = c_ex & (code == C_RST1) & (|chm);
  wire       rst_go = r1_go | (c_ex & (code == C_RSTA));
  wire [1:0] rst_m  = (code == C_RSTA) ? 2'b11 : chm;
  wire       nv_go  = st_ok | rnv_ok;
  wire       ld_now = (st_r == ST_LOAD) & (cnt_r == '0);

  // Store request: wiper copy or direct data byte
  assign nvwr.wr  = nv_go;
  assign nvwr.ch  = st_ok ? chm[1] : rm[1];
  assign nvwr.dat = st_ok ? 8'(w_r[chm[1]]) : dat;

  // ****************************************
  // Wiper setting registers
  // ****************************************
  // Plain scratch registers; only the store request reaches the store
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign w_nxt[i] = (st_r == ST_POR)         ? MID :
                      (ld_now & ldm_r[i])      ? nv_rd[i] :
                      (op_ok & tm[i])          ? op_val(code, w_r[i]) :
                      (rw_ok & rm[i])          ? dat[WW-1:0] :
                      w_r[i];
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      w_r <= {MID, MID};
    end else begin
      w_r <= w_nxt;
    end
  end

  // High-current read state: set by single-wiper restore (not restore-all), left by no-op
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      nv_rd_r <= 1'b0;
    end else if (r1_go) begin
      nv_rd_r <= 1'b1;
    end else if (c_ex && code == C_NOP) begin
      nv_rd_r <= 1'b0;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    ldm_nxt = ldm_r;
    unique case (st_r)
      ST_POR: begin
        st_nxt  = ST_LOAD;
        cnt_nxt = CW'(REST_CYC_P - 1);
        ldm_nxt = 2'b11;
      end
      ST_LOAD: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (rst_go) begin
          st_nxt  = ST_LOAD;
          cnt_nxt = CW'(REST_CYC_P - 1);
          ldm_nxt = rst_m;
        end else if (nv_go) begin
          st_nxt = ST_STORE;
        end
      end
      ST_STORE: begin
        if (!nv_busy) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      st_r  <= ST_POR;
      cnt_r <= '0;
      ldm_r <= 2'b11;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      ldm_r <= ldm_nxt;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Store words read here are plain reads and leave no power state
  wire [31:0] stat_w = (32'(busy) << STB_BUSY) | (32'(nv_rd_r) << STB_NVRD) |
                       (32'(wp_prot) << STB_WP) | (32'(st_r) << STB_ST);
  wire [7:0]  ra     = HADDR[7:0];
  wire [31:0] rd_w   = !hit           ? 32'h00000000 :
                       (ra == A_CMD)  ? 32'(cmd_r) :
                       (ra == A_STAT) ? stat_w :
                       (ra == A_W0)   ? 32'(w_r[0]) :
                       (ra == A_W1)   ? 32'(w_r[1]) :
                       (ra == A_NV0)  ? 32'(nv_rd[0]) :
                       (ra == A_NV1)  ? 32'(nv_rd[1]) :
                       32'h00000000;

  // Zero wait states: read data is caught in the address phase
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      ap_wr_r <= 1'b0;
      ap_a_r  <= 8'h00;
      rdata_r <= 32'h00000000;
      cmd_r   <= CMD_RST;
      rdy_r   <= 1'b1;
      resp_r  <= 1'b0;
    end else begin
      ap_wr_r <= ap_take & HWRITE & hit;
      ap_a_r  <= ra;
      rdy_r   <= 1'b1;
      resp_r  <= 1'b0;
      if (ap_take && !HWRITE) begin
        rdata_r <= rd_w;
      end
      if (ahb_cw) begin
        cmd_r <= HWDATA[16:0];
      end
    end
  end

  assign HRDATA         = rdata_r;
  assign HREADYOUT      = rdy_r;
  assign HRESP          = resp_r;
  assign WIPER0         = w_r[0];
  assign WIPER1         = w_r[1];
  assign NV_READ_ACTIVE = nv_rd_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [31:0] ld_cyc_r;
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      ld_cyc_r <= 32'h00000000;
    end else begin
      ld_cyc_r <= (st_r == ST_LOAD) ? ld_cyc_r + 32'h1 : 32'h00000000;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  por_mid_a: assert property (st_r == ST_POR |=>
    w_r[0] == MID && w_r[1] == MID && st_r == ST_LOAD) else $error("no midscale at power-up");
  load_end_a: assert property (ld_now && ldm_r == 2'b11 |=>
    w_r == $past(nv_rd) && st_r == ST_IDLE) else $error("restore did not load wipers");
  load_time_a: assert property (ld_now |->
    ld_cyc_r == 32'(REST_CYC_P - 1)) else $error("restore length wrong");
  store_copy_a: assert property (st_ok && chm[0] |=>
    nv_rd[0] == $past(w_r[0]) && nv_busy && st_r == ST_STORE) else $error("store failed");
  store_nak_a: assert property (nv_busy |-> busy) else $error("idle during write cycle");
  step_up_a: assert property (op_ok && tm[0] && code == C_INC1 && w_r[0] != FULL |=>
    w_r[0] == $past(w_r[0]) + ONE) else $error("increment wrong");
  inc_sat_a: assert property (op_ok && tm[1] && code == C_INCA && w_r[1] == FULL |=>
    w_r[1] == FULL) else $error("increment wrapped");
  wp_block_a: assert property (c_ex && wp_prot && code != C_RST1 && code != C_RSTA |=>
    $stable(w_r) && !nv_busy) else $error("write passed protect");
  rsvd_nop_a: assert property (c_ex && code >= 4'hC |=>
    $stable(w_r) && st_r == ST_IDLE) else $error("reserved code acted");
  nvrd_clr_a: assert property (c_ex && code == C_NOP |=> !nv_rd_r) else $error("read state kept");
  wp_deflt_a: assert property ($rose(RESETN) |-> wp_prot) else $error("not protected at start");

  restore_all_c: cover property (rst_go && rst_m == 2'b11);
  store_c: cover property (st_ok);
  double_all_c: cover property (op_ok && code == C_DBLA);
endmodule

// ==== logic/dpw_pkg.sv ====
// Package: constants and types of the dual wiper command logic
package dpw_pkg;
  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int WIPER_W  = 8;    // Wiper setting width
  localparam int CLK_MHZ  = 100;  // REF_CLK rate in MHz
  localparam int REST_US  = 300;  // Restore time, us
  localparam int NVWR_MS  = 26;   // Store write cycle, ms
  localparam int REST_CYC = REST_US * CLK_MHZ;
  localparam int NVWR_CYC = NVWR_MS * 1000 * CLK_MHZ;

  // ****************************************
  // Serial bus framing
  // ****************************************
  localparam logic [4:0] I2C_ADDR_HI = 5'h0B;  // Fixed upper address bits
  localparam logic [3:0] BIT_ACK     = 4'h8;   // Bit count at ack slot
  localparam logic [3:0] BIT_REL     = 4'h9;   // Bit count while acking
  localparam logic [3:0] SYNC_RST    = 4'hC;   // SCL, SDA idle high

  // ****************************************
  // Instruction byte
  // ****************************************
  localparam logic [3:0] C_NOP   = 4'h0;
  localparam logic [3:0] C_RST1  = 4'h1;
  localparam logic [3:0] C_STORE = 4'h2;
  localparam logic [3:0] C_HALF1 = 4'h3;
  localparam logic [3:0] C_HALFA = 4'h4;
  localparam logic [3:0] C_DEC1  = 4'h5;
  localparam logic [3:0] C_DECA  = 4'h6;
  localparam logic [3:0] C_RSTA  = 4'h7;
  localparam logic [3:0] C_DBL1  = 4'h8;
  localparam logic [3:0] C_DBLA  = 4'h9;
  localparam logic [3:0] C_INC1  = 4'hA;
  localparam logic [3:0] C_INCA  = 4'hB;
  localparam logic [4:0] SEL_CH0 = 5'h01;  // Channel 0 address
  localparam logic [4:0] SEL_CH1 = 5'h03;  // Channel 1 address

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  A_CMD   = 8'h00;
  localparam logic [7:0]  A_STAT  = 8'h04;
  localparam logic [7:0]  A_W0    = 8'h08;
  localparam logic [7:0]  A_W1    = 8'h0C;
  localparam logic [7:0]  A_NV0   = 8'h10;
  localparam logic [7:0]  A_NV1   = 8'h14;
  localparam logic [16:0] CMD_RST = 17'h00000;
  localparam int STB_BUSY = 0;
  localparam int STB_NVRD = 1;
  localparam int STB_WP   = 2;
  localparam int STB_ST   = 4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_POR   = 4'h1,
    ST_LOAD  = 4'h2,
    ST_IDLE  = 4'h4,
    ST_STORE = 4'h8
  } dpw_state_e;

  typedef struct packed {
    logic       valid;
    logic       is_data;
    logic [7:0] dat;
  } dpw_byte_s;

  typedef struct packed {
    logic       wr;
    logic       ch;
    logic [7:0] dat;
  } dpw_nvwr_s;
endpackage

// ==== logic/dpw_i2c_fe.sv ====
// Serial slave front end: pin sync, framing, address match, byte delivery
`timescale 1ns/1ps
module dpw_i2c_fe
  import dpw_pkg::*;
(
  // Clock and reset
  input  logic      clk,
  input  logic      rst_n,
  // Bus pins and address straps
  input  logic      scl,
  input  logic      sda_i,
  input  logic      ad_hi,
  input  logic      ad_lo,
  output logic      sda_o,
  output logic      sda_oe,
  // Core side
  input  logic      busy,
  output dpw_byte_s rx
);
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       act_r;
  logic       ack_r;
  logic [3:0] bit_r;
  logic [1:0] idx_r;
  logic [7:0] sh_r;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r    <= SYNC_RST;
      s2_r    <= SYNC_RST;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      s1_r    <= {scl, sda_i, ad_hi, ad_lo};
      s2_r    <= s1_r;
      scl_d_r <= s2_r[3];
      sda_d_r <= s2_r[2];
    end
  end

  // Edge and condition detection on the synced lines
  wire       scl_s    = s2_r[3];
  wire       sda_s    = s2_r[2];
  wire       scl_hi   = scl_s & scl_d_r;
  wire       start    = scl_hi & sda_d_r & ~sda_s;
  wire       stop     = scl_hi & ~sda_d_r & sda_s;
  wire       rise     = scl_s & ~scl_d_r;
  wire       fall     = ~scl_s & scl_d_r;
  wire [6:0] my_addr  = {I2C_ADDR_HI, s2_r[1:0]};
  wire       adr_ok   = (sh_r[7:1] == my_addr) & ~sh_r[0] & ~busy;
  wire       later    = idx_r != 2'h0;
  wire       byte_end = act_r & fall & (bit_r == BIT_ACK);
  wire       ack_end  = act_r & fall & (bit_r == BIT_REL);

  assign sda_oe = ack_r;

  // Framing; a missed address drops the frame until the next start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act_r <= 1'b0;
      ack_r <= 1'b0;
      bit_r <= 4'h0;
      idx_r <= 2'h0;
      sh_r  <= 8'h00;
      rx    <= '0;
      sda_o <= 1'b0;
    end else begin
      rx    <= '0;
      sda_o <= 1'b0;
      if (start) begin
        act_r <= 1'b1;
        ack_r <= 1'b0;
        bit_r <= 4'h0;
        idx_r <= 2'h0;
      end else if (stop) begin
        act_r <= 1'b0;
        ack_r <= 1'b0;
      end else if (act_r & rise & ~bit_r[3]) begin
        sh_r  <= {sh_r[6:0], sda_s};
        bit_r <= bit_r + 4'h1;
      end else if (byte_end) begin
        bit_r <= BIT_REL;
        ack_r <= later | adr_ok;
        act_r <= later | adr_ok;
        if (idx_r != 2'h2) begin
          idx_r <= idx_r + 2'h1;
        end
        rx <= '{valid: later, is_data: idx_r == 2'h2, dat: sh_r};
      end else if (ack_end) begin
        bit_r <= 4'h0;
        ack_r <= 1'b0;
      end
    end
  end
endmodule

// ==== logic/dpw_nvstore.sv ====
// Nonvolatile store: two words with a timed internal write cycle
`timescale 1ns/1ps
module dpw_nvstore
  import dpw_pkg::*;
#(
  parameter int             WW       = WIPER_W,
  parameter int             NVWR_CYC_P = NVWR_CYC,
  parameter logic [WW-1:0] NV_INIT  = '0
) (
  // Clock and reset
  input  logic                clk,
  input  logic                rst_n,
  // Write request and state
  input  dpw_nvwr_s           wr,
  output logic                busy,
  output logic [1:0][WW-1:0] rd
);
  localparam int CW = $clog2(NVWR_CYC_P + 1);

  logic [WW-1:0] mem_r [2];
  logic [CW-1:0] cnt_r;

  // Content changes at once; busy covers the write cycle after it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        mem_r[i] <= NV_INIT;
      end
      cnt_r <= '0;
    end else if (wr.wr && cnt_r == '0) begin
      mem_r[wr.ch] <= wr.dat[WW-1:0];
      cnt_r        <= CW'(NVWR_CYC_P - 1);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy  = cnt_r != '0;
  assign rd[0] = mem_r[0];
  assign rd[1] = mem_r[1];
endmodule

// ==== verif/dpw_i2c_host.sv ====
// Serial bus master model issuing commands
`timescale 1ns/1ps
module dpw_i2c_host (
  // Bus lines
  output logic scl,
  output logic sda_low,
  input  wire  sda
);
  initial {scl, sda_low} = 2'b10;
  // One bit: data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #31.25 scl = 1'b1;
    #31.25 s = sda;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  // Start, address with write bit, instruction if acked, stop
  task automatic cmd(input logic [6:0] sa, input logic [7:0] ins, output logic ack);
    logic [17:0] fr;
    logic        s;
    fr = {sa, 1'b0, 1'b1, ins, 1'b1};
    ack = 1'b0;
    sda_low = 1'b1;
    #31.25 scl = 1'b0;
    for (int i = 17; i >= 0; i--) begin
      bit_io(fr[i], s);
      if (i == 9) ack = ~s;
      if (i == 9 && s) break;
    end
    // Stop; clock then stands high between frames
    sda_low = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 sda_low = 1'b0;
    // Bus free time, else a start right after would hide this stop
    #125;
  endtask
endmodule

// ==== verif/dpw_wiper_top_tb_top.sv ====
// Self-checking bench of the two-wiper command logic
`timescale 1ns/1ps
module dpw_wiper_top_tb_top;
  import dpw_pkg::*;
  // ****
  // Signals and counters
  // ****
  logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hw = 1'b0, wp_n = 1'b1;
  logic        ahi = 1'b0, alo = 1'b0, hro, hresp, sdo, sdoe, nvr, mlow, mscl, ack;
  logic [1:0]  htr = 2'h0;
  logic [7:0]  w0, w1, e0, e1, v;
  logic [3:0]  c;
  logic [2:0]  ch;
  logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, rd, seed = 32'h3F;
  wire         sda = (sdoe ? sdo : 1'b1) & ~mlow;
  int          n_mismatch = 0, compares = 0;
  time         t0;
  always #5 clk = ~clk;
  // Short counts keep the run brief
  dpw_wiper_top #(.REST_CYC_P(20), .NVWR_CYC_P(400)) dpw_wiper_top_i (
    .REF_CLK(clk), .RESETN(rstn), .HSEL(hsel), .HADDR(ha), .HTRANS(htr), .HWRITE(hw),
    .HSIZE(3'h2), .HWDATA(hwd), .HREADY(hro), .HRDATA(hrd), .HREADYOUT(hro), .HRESP(hresp),
    .SCL(mscl), .SDA_I(sda), .SDA_O(sdo), .SDA_OE(sdoe), .ADDR_SELECT_HI(ahi),
    .ADDR_SELECT_LO(alo), .WP_N(wp_n), .WIPER0(w0), .WIPER1(w1), .NV_READ_ACTIVE(nvr));
  dpw_i2c_host dpw_i2c_host_i (.scl(mscl), .sda_low(mlow), .sda(sda));
  // ****
  // Checks and expectations
  // ****
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cv(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t value %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic cf(input logic g, input logic e);
    cv({31'h0, g}, {31'h0, e});
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Wiper after one quick command; saturates rather than wraps
  function automatic logic [7:0] nx(input logic [3:0] k, input logic [7:0] x);
    case (k)
      C_INC1, C_INCA: return (x == 8'hFF) ? x : x + 8'h01;
      C_DEC1, C_DECA: return (x == 8'h00) ? x : x - 8'h01;
      C_DBL1, C_DBLA: return (x == 8'h00) ? 8'h01 : (x[7] ? 8'hFF : x << 1);
      C_HALF1, C_HALFA: return x >> 1;
      default: return x;
    endcase
  endfunction
  // ****
  // Bus tasks: wait on ready; command and wiper writes add one fixed clock after
  // ****
  task automatic wt();
    int i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hro !== 1'b1 && i < 64);
    if (hro !== 1'b1) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    ha <= {24'h0, a};
    hw <= w;
    htr <= 2'h2;
    wt();
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    wt();
    rd = hrd;
  endtask
  task automatic cmd(input logic [3:0] k, input logic [2:0] s);
    ahb(1'b1, A_CMD, {24'h0, 1'b1, k, s});
    @(posedge clk);
  endtask
  task automatic setw(input logic s, input logic [7:0] x);
    ahb(1'b1, A_CMD, {15'h0, 1'b1, x, 3'h0, s ? SEL_CH1 : SEL_CH0});
    @(posedge clk);
  endtask
  task automatic idle();
    int i = 0;
    do begin
      ahb(1'b0, A_STAT, 32'h0);
      i++;
    end while (rd[STB_BUSY] !== 1'b0 && i < 1000);
    if (rd[STB_BUSY] !== 1'b0) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    rd = xs();
    {ahi, alo} <= rd[1:0];
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t0 = $time;
    @(posedge clk);
    idle();
    cf($time - t0 >= 200, 1'b1);
    cv(w0, 8'h80);
    cv(w1, 8'h80);
    wp_n <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(C_INC1, SEL_CH0[2:0]);
    cv(w0, 8'h80);
    ahb(1'b0, A_STAT, 32'h0);
    cf(rd[STB_WP], 1'b1);
    wp_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Random quick commands with edge values mixed in
    for (int k = 0; k < 60; k++) begin
      rd = xs();
      e0 = (k % 4 == 0) ? 8'hFF : rd[7:0];
      e1 = (k % 4 == 1) ? 8'h00 : rd[15:8];
      c = rd[19:16];
      if (c inside {C_NOP, C_RST1, C_STORE, C_RSTA}) c = c | 4'h8;
      ch = rd[20] ? SEL_CH1[2:0] : SEL_CH0[2:0];
      setw(1'b0, e0);
      setw(1'b1, e1);
      cmd(c, ch);
      if (c inside {C_HALFA, C_DECA, C_DBLA, C_INCA} || ch == SEL_CH0[2:0]) e0 = nx(c, e0);
      if (c inside {C_HALFA, C_DECA, C_DBLA, C_INCA} || ch == SEL_CH1[2:0]) e1 = nx(c, e1);
      cv(w0, e0);
      cv(w1, e1);
    end
    setw(1'b0, 8'h00);
    repeat (8) cmd(C_DBL1, SEL_CH0[2:0]);
    cv(w0, 8'h80);
    cmd(C_DBL1, SEL_CH0[2:0]);
    cv(w0, 8'hFF);
    repeat (8) cmd(C_HALF1, SEL_CH0[2:0]);
    cv(w0, 8'h00);
    cmd(C_DEC1, SEL_CH0[2:0]);
    cv(w0, 8'h00);
    // Step-all at full scale must hold, not wrap
    setw(1'b1, 8'hFF);
    cmd(C_INCA, SEL_CH0[2:0]);
    cv(w1, 8'hFF);
    // Store, poll during the write cycle, then restore
    rd = xs();
    v = rd[7:0];
    setw(1'b0, v);
    t0 = $time;
    cmd(C_STORE, SEL_CH0[2:0]);
    dpw_i2c_host_i.cmd({I2C_ADDR_HI, ahi, alo}, 8'h80, ack);
    cf(ack, 1'b0);
    @(posedge clk);
    idle();
    cf($time - t0 >= 4000, 1'b1);
    ahb(1'b0, A_NV0, 32'h0);
    cv(rd[7:0], v);
    cf(nvr, 1'b0);
    setw(1'b0, ~v);
    cmd(C_RST1, SEL_CH0[2:0]);
    idle();
    cv(w0, v);
    cf(nvr, 1'b1);
    cmd(C_NOP, SEL_CH0[2:0]);
    cf(nvr, 1'b0);
    setw(1'b1, 8'h00);
    cmd(C_RSTA, SEL_CH0[2:0]);
    idle();
    cv(w1, 8'h80);
    // Register form straight into store 1; the wiper must not follow
    rd = xs();
    v = rd[7:0];
    ahb(1'b1, A_CMD, {15'h0, 1'b1, v, 3'h1, SEL_CH1});
    @(posedge clk);
    idle();
    ahb(1'b0, A_NV1, 32'h0);
    cv(rd[7:0], v);
    cv(w1, 8'h80);
    // Serial commands: foreign address ignored, own one obeyed
    dpw_i2c_host_i.cmd({I2C_ADDR_HI, ahi, ~alo}, {1'b1, C_INC1, SEL_CH1[2:0]}, ack);
    cf(ack, 1'b0);
    dpw_i2c_host_i.cmd({I2C_ADDR_HI, ahi, alo}, {1'b1, C_INC1, SEL_CH1[2:0]}, ack);
    cf(ack, 1'b1);
    @(posedge clk);
    cv(w1, 8'h81);
    ahb(1'b0, 8'hFC, 32'h0);
    cv(rd, 32'h0);
    ahb(1'b0, A_W1, 32'h0);
    cv(rd[7:0], 8'h81);
    cf(hresp, 1'b0);
    complete_run();
  end
endmodule
